// File: logic/cbu_pkg.sv
// shared constants and types of the conditional branch unit
package cbu_pkg;

    // register bus geometry
    localparam int          CBU_ADDR_W         = 3;
    localparam int          CBU_DATA_W         = 16;

    // register offsets
    localparam logic [2:0]  CBU_OFF_CTRL       = 3'h0;
    localparam logic [2:0]  CBU_OFF_FLAGS      = 3'h1;
    localparam logic [2:0]  CBU_OFF_PC         = 3'h2;
    localparam logic [2:0]  CBU_OFF_STAT       = 3'h3;
    localparam logic [2:0]  CBU_OFF_TAKEN_CNT  = 3'h4;
    localparam logic [2:0]  CBU_OFF_SKIP_CNT   = 3'h5;

    // control fields
    localparam int          CBU_CTRL_EN_BIT    = 0;
    localparam int          CBU_CTRL_CLR_BIT   = 1;
    localparam logic        CBU_CTRL_EN_RST    = 1'b0;

    // status fields
    localparam int          CBU_STAT_BUSY_BIT  = 0;
    localparam int          CBU_STAT_TAKEN_BIT = 1;
    localparam int          CBU_STAT_UNSUP_BIT = 2;

    // reset values
    localparam logic [7:0]  CBU_FLAGS_RST      = 8'h00;
    localparam logic [15:0] CBU_PC_RST         = 16'h0000;

    // instruction word fields
    localparam int          CBU_OP_HI          = 15;
    localparam int          CBU_OP_LO          = 11;
    localparam logic [4:0]  CBU_OP_BRANCH      = 5'h1E;
    localparam int          CBU_POL_BIT        = 10;
    localparam int          CBU_OFS_HI         = 9;
    localparam int          CBU_OFS_LO         = 3;
    localparam int          CBU_OFS_W          = 7;
    localparam int          CBU_SEL_HI         = 2;
    localparam int          CBU_SEL_LO         = 0;

    // flag select codes
    localparam logic [2:0]  CBU_SEL_C          = 3'h0;
    localparam logic [2:0]  CBU_SEL_N          = 3'h2;
    localparam logic [2:0]  CBU_SEL_S          = 3'h4;
    localparam logic [2:0]  CBU_SEL_H          = 3'h5;
    localparam logic [2:0]  CBU_SEL_T          = 3'h6;

    // cycles per branch
    localparam int          CBU_CYC_SKIP       = 1;
    localparam int          CBU_CYC_TAKEN      = 2;

    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } cbu_flags_t;

    typedef struct packed {
        logic                   hit;
        logic                   taken;
        logic [CBU_OFS_W-1:0]   offset;
    } cbu_branch_t;

    typedef enum logic [1:0] {
        CBU_ST_IDLE  = 2'b01,
        CBU_ST_FLUSH = 2'b10
    } cbu_state_t;

endpackage : cbu_pkg

// File: logic/cbu_cond_eval.sv
// condition decode and flag test for one branch word
`timescale 1ns/1ns
module cbu_cond_eval
    import cbu_pkg::*;
(
    input  wire logic [15:0] instr,
    input  wire cbu_flags_t  flags,
    output cbu_branch_t      branch
);

    logic       is_br;
    logic       pol_clr;
    logic [2:0] sel;
    logic       sign_lt;

    assign is_br   = (instr[CBU_OP_HI:CBU_OP_LO] == CBU_OP_BRANCH);
    assign pol_clr = instr[CBU_POL_BIT];
    assign sel     = instr[CBU_SEL_HI:CBU_SEL_LO];
    // signed test taken from n and v directly, not from a cached sign flag
    assign sign_lt = flags.n ^ flags.v;

    always_comb begin
        branch        = '0;
        branch.offset = instr[CBU_OFS_HI:CBU_OFS_LO];
        if (is_br) begin
            unique case ({pol_clr, sel})
                {1'b1, CBU_SEL_C}: begin
                    branch.hit   = 1'b1;
                    branch.taken = ~flags.c;
                end
                {1'b0, CBU_SEL_C}: begin
                    branch.hit   = 1'b1;
                    branch.taken = flags.c;
                end
                {1'b0, CBU_SEL_N}: begin
                    branch.hit   = 1'b1;
                    branch.taken = flags.n;
                end
                {1'b1, CBU_SEL_N}: begin
                    branch.hit   = 1'b1;
                    branch.taken = ~flags.n;
                end
                {1'b1, CBU_SEL_S}: begin
                    branch.hit   = 1'b1;
                    branch.taken = ~sign_lt;
                end
                {1'b0, CBU_SEL_S}: begin
                    branch.hit   = 1'b1;
                    branch.taken = sign_lt;
                end
                {1'b0, CBU_SEL_H}: begin
                    branch.hit   = 1'b1;
                    branch.taken = flags.h;
                end
                {1'b1, CBU_SEL_H}: begin
                    branch.hit   = 1'b1;
                    branch.taken = ~flags.h;
                end
                {1'b0, CBU_SEL_T}: begin
                    branch.hit   = 1'b1;
                    branch.taken = flags.t;
                end
                // other flag tests belong to other units
                default: begin
                    branch.hit   = 1'b0;
                    branch.taken = 1'b0;
                end
            endcase
        end
    end

endmodule : cbu_cond_eval

// File: logic/cbu_target_add.sv
// relative and sequential next-address adders
`timescale 1ns/1ns
module cbu_target_add
    import cbu_pkg::*;
#(
    parameter int PC_W = 16
) (
    input  wire logic [PC_W-1:0]      pc,
    input  wire logic [CBU_OFS_W-1:0] offset,
    output logic      [PC_W-1:0]      target,
    output logic      [PC_W-1:0]      seq
);

    logic [PC_W-1:0] ofs_ext;

    // two's complement offset reaches both backward and forward
    assign ofs_ext = {{(PC_W-CBU_OFS_W){offset[CBU_OFS_W-1]}}, offset};
    assign target  = pc + ofs_ext + PC_W'(1);
    assign seq     = pc + PC_W'(1);

endmodule : cbu_target_add

// File: logic/cbu_branch_unit.sv
// conditional branch unit: flag tests, pc update and register port
//
// Overview of operation
// - taken branch loads pc plus offset plus one
// - carry clear or set selects higher/lower branches
// - negative set or clear selects minus/plus
// - signed ge taken when n xor v is zero
// - signed lt taken when n xor v is one
// - half-carry-set branch needs half carry one
// - half-carry-clear branch needs half carry zero
// - transfer-bit branch needs transfer bit one
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
module cbu_branch_unit
    import cbu_pkg::*;
#(
    parameter int PC_W  = 16,
    parameter int CNT_W = 16
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESET_N,
    input  wire logic                  INSTR_VALID,
    input  wire logic [15:0]           INSTR_WORD,
    input  wire logic [CBU_ADDR_W-1:0] REG_ADDR,
    input  wire logic [CBU_DATA_W-1:0] REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic      [CBU_DATA_W-1:0] REG_RDATA,
    output logic      [PC_W-1:0]       PC_OUT,
    output logic      [7:0]            FLAGS_OUT,
    output logic                       FLUSH,
    output logic                       BRANCH_DONE,
    output logic                       BRANCH_TAKEN,
    output logic                       UNSUPPORTED
);

    cbu_state_t          state_q;
    cbu_state_t          state_d;
    logic                enable_q;
    cbu_flags_t          flags_q;
    logic [PC_W-1:0]     pc_q;
    logic [PC_W-1:0]     pc_d;
    logic                flush_q;
    logic                done_q;
    logic                taken_pulse_q;
    logic                unsup_q;
    logic                last_taken_q;
    logic                unsup_sticky_q;
    logic [CNT_W-1:0]    taken_cnt_q;
    logic [CNT_W-1:0]    skip_cnt_q;
    logic [CNT_W-1:0]    taken_cnt_d;
    logic [CNT_W-1:0]    skip_cnt_d;
    logic [CBU_DATA_W-1:0] rdata_q;
    logic [CBU_DATA_W-1:0] rd_mux;
    logic [CBU_DATA_W-1:0] stat_word;

    cbu_branch_t         branch;
    logic [PC_W-1:0]     target;
    logic [PC_W-1:0]     seq;
    logic                accept;
    logic                go_taken;
    logic                go_skip;
    logic                go_unsup;
    logic                finish_taken;
    logic                wr_ctrl;
    logic                wr_flags;
    logic                wr_pc;
    logic                cnt_clr;

    cbu_cond_eval u_cond (
        .instr  (INSTR_WORD),
        .flags  (flags_q),
        .branch (branch)
    );

    cbu_target_add #(
        .PC_W (PC_W)
    ) u_add (
        .pc     (pc_q),
        .offset (branch.offset),
        .target (target),
        .seq    (seq)
    );

    // a word offered during the flush cycle is the stale fetch and is dropped
    assign accept       = INSTR_VALID && enable_q && (state_q == CBU_ST_IDLE);
    assign finish_taken = (state_q == CBU_ST_FLUSH);

    assign wr_ctrl  = REG_WR && (REG_ADDR == CBU_OFF_CTRL);
    assign wr_flags = REG_WR && (REG_ADDR == CBU_OFF_FLAGS);
    assign wr_pc    = REG_WR && (REG_ADDR == CBU_OFF_PC);
    assign cnt_clr  = wr_ctrl && REG_WDATA[CBU_CTRL_CLR_BIT];

    // exactly one outcome per accepted word
    always_comb begin
        go_taken = 1'b0;
        go_skip  = 1'b0;
        go_unsup = 1'b0;
        if (accept) begin
            if (!branch.hit) begin
                go_unsup = 1'b1;
            end else if (branch.taken) begin
                go_taken = 1'b1;
            end else begin
                go_skip = 1'b1;
            end
        end
    end

    // sequencer: flush state only exists for taken branches
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CBU_ST_IDLE: begin
                if (go_taken) begin
                    state_d = CBU_ST_FLUSH;
                end
            end
            CBU_ST_FLUSH: begin
                state_d = CBU_ST_IDLE;
            end
            default: begin
                state_d = CBU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= CBU_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // next pc; software load wins over a branch in the same cycle
    always_comb begin
        pc_d = pc_q;
        if (wr_pc) begin
            pc_d = REG_WDATA[PC_W-1:0];
        end else if (go_taken) begin
            pc_d = target;
        end else if (go_skip) begin
            pc_d = seq;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pc_q <= CBU_PC_RST[PC_W-1:0];
        end else begin
            pc_q <= pc_d;
        end
    end

    // flags change only by software; branch logic only reads them
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_q <= cbu_flags_t'(CBU_FLAGS_RST);
        end else if (wr_flags) begin
            flags_q <= cbu_flags_t'(REG_WDATA[7:0]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_q <= CBU_CTRL_EN_RST;
        end else if (wr_ctrl) begin
            enable_q <= REG_WDATA[CBU_CTRL_EN_BIT];
        end
    end

    // completion pulses: one cycle after skip, two after taken
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= go_taken;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            done_q <= 1'b0;
        end else begin
            done_q <= go_skip || finish_taken;
        end
    end

    // taken pulse rides with done in the second cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            taken_pulse_q <= 1'b0;
        end else begin
            taken_pulse_q <= finish_taken;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            unsup_q <= 1'b0;
        end else begin
            unsup_q <= go_unsup;
        end
    end

    // outcome of the last word of this group
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            last_taken_q <= 1'b0;
        end else if (go_taken || go_skip) begin
            last_taken_q <= go_taken;
        end
    end

    // sticky unsupported; event beats clear in same cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            unsup_sticky_q <= 1'b0;
        end else if (go_unsup) begin
            unsup_sticky_q <= 1'b1;
        end else if (cnt_clr) begin
            unsup_sticky_q <= 1'b0;
        end
    end

    // outcome counters; a counted event in the clear cycle leaves one
    always_comb begin
        taken_cnt_d = taken_cnt_q + CNT_W'(go_taken);
        skip_cnt_d  = skip_cnt_q + CNT_W'(go_skip);
        if (cnt_clr) begin
            taken_cnt_d = CNT_W'(go_taken);
            skip_cnt_d  = CNT_W'(go_skip);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            taken_cnt_q <= '0;
        end else begin
            taken_cnt_q <= taken_cnt_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            skip_cnt_q <= '0;
        end else begin
            skip_cnt_q <= skip_cnt_d;
        end
    end

    // status word built from named bit positions
    always_comb begin
        stat_word                     = '0;
        stat_word[CBU_STAT_BUSY_BIT]  = flush_q;
        stat_word[CBU_STAT_TAKEN_BIT] = last_taken_q;
        stat_word[CBU_STAT_UNSUP_BIT] = unsup_sticky_q;
    end

    // read mux; counters wrap silently, software reads differences
    always_comb begin
        rd_mux = '0;
        unique case (REG_ADDR)
            CBU_OFF_CTRL: begin
                rd_mux = CBU_DATA_W'(enable_q);
            end
            CBU_OFF_FLAGS: begin
                rd_mux = CBU_DATA_W'(flags_q);
            end
            CBU_OFF_PC: begin
                rd_mux = CBU_DATA_W'(pc_q);
            end
            CBU_OFF_STAT: begin
                rd_mux = stat_word;
            end
            CBU_OFF_TAKEN_CNT: begin
                rd_mux = CBU_DATA_W'(taken_cnt_q);
            end
            CBU_OFF_SKIP_CNT: begin
                rd_mux = CBU_DATA_W'(skip_cnt_q);
            end
            // unmapped offsets read as zero
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= '0;
        end else if (REG_RD) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= '0;
        end
    end

    assign REG_RDATA    = rdata_q;
    assign PC_OUT       = pc_q;
    assign FLAGS_OUT    = flags_q;
    assign FLUSH        = flush_q;
    assign BRANCH_DONE  = done_q;
    assign BRANCH_TAKEN = taken_pulse_q;
    assign UNSUPPORTED  = unsup_q;

endmodule : cbu_branch_unit

// File: verif/cbu_branch_unit_chk.sv
// port assertions for the conditional branch unit
`timescale 1ns/1ns
module cbu_branch_unit_chk
    import cbu_pkg::*;
#(
    parameter int PC_W  = 16,
    parameter int CNT_W = 16
) (
    input wire logic                  CORE_CLK,
    input wire logic                  RESET_N,
    input wire logic                  INSTR_VALID,
    input wire logic [15:0]           INSTR_WORD,
    input wire logic [CBU_ADDR_W-1:0] REG_ADDR,
    input wire logic [CBU_DATA_W-1:0] REG_WDATA,
    input wire logic                  REG_WR,
    input wire logic                  REG_RD,
    input wire logic [CBU_DATA_W-1:0] REG_RDATA,
    input wire logic [PC_W-1:0]       PC_OUT,
    input wire logic [7:0]            FLAGS_OUT,
    input wire logic                  FLUSH,
    input wire logic                  BRANCH_DONE,
    input wire logic                  BRANCH_TAKEN,
    input wire logic                  UNSUPPORTED
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    // flag test of a word, polarity bit inverts it
    function automatic logic hit(logic [15:0] w, cbu_flags_t f);
        logic b;
        case (w[2:0])
            CBU_SEL_C: b = f.c;
            CBU_SEL_N: b = f.n;
            CBU_SEL_S: b = f.n ^ f.v;
            CBU_SEL_H: b = f.h;
            default:   b = f.t;
        endcase
        return b ^ w[CBU_POL_BIT];
    endfunction : hit

    property p_flags_hold;
        !(REG_WR && REG_ADDR == CBU_OFF_FLAGS) |=> $stable(FLAGS_OUT);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
    property p_flush_done;
        FLUSH |=> BRANCH_DONE && BRANCH_TAKEN && !FLUSH;
    endproperty
    a_flush_done: assert property (p_flush_done) else $error("flush not ended");
    property p_taken_flushed;
        BRANCH_TAKEN |-> BRANCH_DONE && $past(FLUSH);
    endproperty
    a_taken_flushed: assert property (p_taken_flushed) else $error("taken early");
    property p_flush_pc;
        FLUSH |-> PC_OUT == PC_W'($past(PC_OUT)
            + PC_W'(signed'($past(INSTR_WORD[CBU_OFS_HI:CBU_OFS_LO]))) + 1);
    endproperty
    a_flush_pc: assert property (p_flush_pc) else $error("bad target");
    property p_taken_cond;
        FLUSH |-> hit($past(INSTR_WORD), $past(FLAGS_OUT));
    endproperty
    a_taken_cond: assert property (p_taken_cond) else $error("taken wrongly");
    property p_skip;
        BRANCH_DONE && !BRANCH_TAKEN |->
            PC_OUT == PC_W'($past(PC_OUT) + 1) && !hit($past(INSTR_WORD), $past(FLAGS_OUT));
    endproperty
    a_skip: assert property (p_skip) else $error("bad skip");
    property p_unsup;
        UNSUPPORTED |-> PC_OUT == $past(PC_OUT) && !FLUSH && !BRANCH_DONE;
    endproperty
    a_unsup: assert property (p_unsup) else $error("pc moved on foreign word");
    property p_rdata;
        !REG_RD |=> REG_RDATA == '0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data not idle");
endmodule : cbu_branch_unit_chk

bind cbu_branch_unit cbu_branch_unit_chk #(.PC_W(PC_W), .CNT_W(CNT_W)) u_chk (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PC_OUT(PC_OUT), .FLAGS_OUT(FLAGS_OUT),
    .FLUSH(FLUSH), .BRANCH_DONE(BRANCH_DONE), .BRANCH_TAKEN(BRANCH_TAKEN),
    .UNSUPPORTED(UNSUPPORTED));

// File: verif/tb_top.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ns
module tb_top;
    import cbu_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata, pc_out, exp_pc, n_tk, n_sk;
    logic [7:0]  flags_out, exp_fl;
    logic        flush, done, taken, unsup;
    logic [6:0]  ofs;
    logic        lt_exp = 1'b0;
    logic [2:0]  sels [5] = '{CBU_SEL_C, CBU_SEL_N, CBU_SEL_S, CBU_SEL_H, CBU_SEL_T};
    logic [6:0]  corner [4] = '{7'h40, 7'h3F, 7'h00, 7'h7F};
    int          n_errors = 0;
    int          cmp_count = 0;
    int          seed = 32'h9040;
    int          cyc = 0;

    cbu_branch_unit u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .INSTR_VALID(instr_valid),
        .INSTR_WORD(instr_word), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PC_OUT(pc_out), .FLAGS_OUT(flags_out),
        .FLUSH(flush), .BRANCH_DONE(done), .BRANCH_TAKEN(taken), .UNSUPPORTED(unsup));

    always #25 clk = ~clk;

    task automatic report_and_stop;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // generous ceiling, the run needs under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd

    function automatic logic want(input logic [15:0] w, input cbu_flags_t f);
        case (w[2:0])
            CBU_SEL_C: return f.c ^ w[CBU_POL_BIT];
            CBU_SEL_N: return f.n ^ w[CBU_POL_BIT];
            CBU_SEL_S: return f.n ^ f.v ^ w[CBU_POL_BIT];
            CBU_SEL_H: return f.h ^ w[CBU_POL_BIT];
            default:   return f.t;
        endcase
    endfunction : want

    task automatic br(input logic [15:0] w, input logic en);
        logic        sup, t;
        logic [15:0] npc;
        sup = w[15:11] == CBU_OP_BRANCH && w[2:0] inside {CBU_SEL_C, CBU_SEL_N, CBU_SEL_S,
              CBU_SEL_H, CBU_SEL_T} && !(w[2:0] == CBU_SEL_T && w[CBU_POL_BIT]);
        t = en && sup && want(w, exp_fl);
        npc = !(en && sup) ? exp_pc : exp_pc + 16'h0001;
        if (t) npc = npc + {{9{w[9]}}, w[9:3]};
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        @(posedge clk);
        // held into the flush cycle on purpose, must be dropped
        instr_valid <= t;
        #1 chk(pc_out, npc);
        chk(16'({flush, done, taken, unsup}), 16'({t, en && sup && !t, 1'b0, en && !sup}));
        if (t) begin
            @(posedge clk);
            instr_valid <= 1'b0;
            #1 chk(pc_out, npc);
            chk(16'({flush, done, taken}), 16'h0003);
            n_tk++;
        end else if (en && sup) begin
            n_sk++;
        end
        if (en && sup) begin
            lt_exp = t;
        end
        chk(16'(flags_out), 16'(exp_fl));
        exp_pc = npc;
    endtask : br

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(pc_out, CBU_PC_RST);
        chk(16'(flags_out), 16'(CBU_FLAGS_RST));
        exp_pc = CBU_PC_RST;
        exp_fl = CBU_FLAGS_RST;
        n_tk = 16'h0000;
        n_sk = 16'h0000;
        br({CBU_OP_BRANCH, 1'b1, 7'h05, CBU_SEL_C}, 1'b0);
        wr(CBU_OFF_CTRL, 16'h0003);
        rd(CBU_OFF_CTRL, 16'h0001);
        wr(3'h7, 16'hFFFF);
        rd(3'h6, 16'h0000);
        for (int i = 0; i < 240; i++) begin
            ofs = (i < 4) ? corner[i] : 7'($random(seed));
            exp_fl = 8'($random(seed));
            exp_pc = (i < 2) ? 16'hFFFF : 16'($random(seed));
            wr(CBU_OFF_FLAGS, 16'(exp_fl));
            wr(CBU_OFF_PC, exp_pc);
            br({CBU_OP_BRANCH, 1'(i / 5), ofs, sels[i % 5]}, 1'b1);
        end
        // chained words with no register traffic between them
        for (int i = 0; i < 30; i++) begin
            br({CBU_OP_BRANCH, 1'($random(seed)), 7'($random(seed)), sels[i % 5]}, 1'b1);
        end
        br({CBU_OP_BRANCH, 1'b0, 7'h11, 3'h1}, 1'b1);
        br({CBU_OP_BRANCH, 1'b0, 7'h11, 3'h7}, 1'b1);
        br(16'h0000, 1'b1);
        rd(CBU_OFF_FLAGS, 16'(exp_fl));
        rd(CBU_OFF_TAKEN_CNT, n_tk);
        rd(CBU_OFF_SKIP_CNT, n_sk);
        rd(CBU_OFF_STAT, 16'({1'b1, lt_exp, 1'b0}));
        rd(CBU_OFF_PC, exp_pc);
        // clear drops counters and sticky, keeps enable
        wr(CBU_OFF_CTRL, 16'h0003);
        rd(CBU_OFF_STAT, 16'({1'b0, lt_exp, 1'b0}));
        rd(CBU_OFF_TAKEN_CNT, 16'h0000);
        rd(CBU_OFF_CTRL, 16'h0001);
        wr(CBU_OFF_CTRL, 16'h0000);
        br({CBU_OP_BRANCH, 1'b1, 7'h22, CBU_SEL_H}, 1'b0);
        // second reset in mid-run brings every register back
        wr(CBU_OFF_CTRL, 16'h0001);
        wr(CBU_OFF_PC, 16'h1234);
        rst_n <= 1'b0;
        #1 chk(pc_out, CBU_PC_RST);
        chk(16'({flags_out, flush, done, taken, unsup}), 16'h0000);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(pc_out, CBU_PC_RST);
        rd(CBU_OFF_CTRL, 16'h0000);
        rd(CBU_OFF_FLAGS, 16'(CBU_FLAGS_RST));
        report_and_stop();
    end
endmodule : tb_top
